// ===== core/dmatc_pkg.sv
// ==========================================================================
// Shared constants for the transfer cycle sequencer
// ==========================================================================
package dmatc_pkg;

  // ========================================================================
  // Bus-clock counts per bus cycle
  // ========================================================================
  localparam logic [2:0] DMATC_BASE_CLKS = 3'h1; // Internal no-wait access
  localparam logic [2:0] DMATC_EXT_CLKS  = 3'h2; // External access, no wait
  localparam logic [2:0] DMATC_WAIT_CLKS = 3'h1; // Added by a software wait

  // ========================================================================
  // Target area codes
  // ========================================================================
  localparam logic [1:0] DMATC_AREA_INT = 2'h0; // Internal ROM/RAM
  localparam logic [1:0] DMATC_AREA_SFR = 2'h1; // SFR area, always waited
  localparam logic [1:0] DMATC_AREA_EXT = 2'h2; // External separate bus

  // ========================================================================
  // Sequencer states
  // ========================================================================
  typedef enum logic [2:0] {
    DMATC_IDLE  = 3'b000,
    DMATC_GRANT = 3'b001,
    DMATC_READ  = 3'b010,
    DMATC_WRITE = 3'b011,
    DMATC_DONE  = 3'b100
  } dmatc_state_e;

endpackage : dmatc_pkg

// ===== core/dmatc_fifo.sv
`timescale 1ns/1ps
// ==========================================================================
// Small valid/ready FIFO carrying finished transfer units
// ==========================================================================
module dmatc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_b,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  // ========================================================================
  // State
  // ========================================================================
  typedef struct packed {
    logic [AW-1:0] wr;   // Write pointer
    logic [AW-1:0] rd;   // Read pointer
    logic [AW:0]   cnt;  // Occupancy
  } dmatc_fifo_s;

  dmatc_fifo_s      st_q;                 // Registered pointers
  dmatc_fifo_s      st_d;                 // Next pointers
  logic [WIDTH-1:0] mem_q [DEPTH];        // Storage, no reset needed
  logic             push;                 // Accepted write
  logic             pop;                  // Accepted read

  assign in_ready  = (st_q.cnt != (AW+1)'(DEPTH)); // Honest full
  assign out_valid = (st_q.cnt != '0);             // Honest empty
  assign out_data  = mem_q[st_q.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Pointer update
  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.wr = st_q.wr + AW'(1);
    end
    if (pop) begin
      st_d.rd = st_q.rd + AW'(1);
    end
    st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // Pointer register
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Storage write
  always_ff @(posedge mclk) begin
    if (push) begin
      mem_q[st_q.wr] <= in_data;
    end
  end

endmodule : dmatc_fifo

// ===== core/dmatc_seq.sv
`timescale 1ns/1ps
module dmatc_seq #(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // Transfer request
  input  wire logic        req,
  input  wire logic        unit16,
  input  wire logic [23:0] src_addr,
  input  wire logic [23:0] dst_addr,
  input  wire logic [1:0]  src_area,
  input  wire logic [1:0]  dst_area,
  input  wire logic        src_wait,
  input  wire logic        dst_wait,
  input  wire logic        src_bus8,
  input  wire logic        dst_bus8,
  // CPU arbitration
  output logic             bus_req,
  input  wire logic        bus_gnt,
  output logic             busy,
  output logic             done,
  // Target bus
  output logic [23:0]      addr,
  output logic             rd_strobe,
  output logic             wr_strobe,
  output logic [15:0]      wdata,
  input  wire logic [15:0] rdata,
  // Completed unit stream
  output logic             unit_valid,
  input  wire logic        unit_ready,
  output logic [15:0]      unit_data
);

  // ========================================================================
  // State
  // ========================================================================
  // Everything the sequencer remembers, registered as one word
  typedef struct packed {
    dmatc_pkg::dmatc_state_e st;   // Sequencer state
    logic [2:0]  clk_left;         // Bus clocks left in this cycle
    logic        second;           // Second byte cycle in progress
    logic [15:0] data;             // Assembled unit
    logic        bus_req;          // Bus wanted from the CPU
    logic        busy;             // Unit in flight
    logic        done;             // One-clock end pulse
    logic [23:0] addr;             // Target address
    logic        rd;               // Read strobe
    logic        wr;               // Write strobe
    logic [15:0] wdata;            // Write word, bytes in low lane
    logic        push;             // Hand unit to FIFO
  } dmatc_seq_s;

  dmatc_seq_s s_q;                 // Registered state
  dmatc_seq_s s_d;                 // Next state
  logic       fifo_rdy;            // FIFO can take a unit
  logic       src_split;           // Read needs two cycles
  logic       dst_split;           // Write needs two cycles

  // Not latched: the request side must hold its attributes while busy
  // Two cycles for 16-bit units on odd address or byte bus
  assign src_split = unit16 && (src_bus8 || src_addr[0]);
  assign dst_split = unit16 && (dst_bus8 || dst_addr[0]);

  // ========================================================================
  // Cycle length, in bus clocks
  // ========================================================================
  // External cycles start at two clocks; a wait or the SFR area adds one
  function automatic logic [2:0] cyc_len(input logic [1:0] area, input logic waited);
    logic [2:0] n;
    n = (area == dmatc_pkg::DMATC_AREA_EXT) ? dmatc_pkg::DMATC_EXT_CLKS
                                            : dmatc_pkg::DMATC_BASE_CLKS;
    if (waited || area == dmatc_pkg::DMATC_AREA_SFR) begin
      n = n + dmatc_pkg::DMATC_WAIT_CLKS;
    end
    return n;
  endfunction : cyc_len

  // ========================================================================
  // Sequencer
  // ========================================================================
  // Next-state logic, one bus clock per edge
  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    s_d.push = 1'b0;
    unique case (s_q.st)
      dmatc_pkg::DMATC_IDLE: begin
        // Wait for request and FIFO room, so no unit is ever dropped
        if (req && fifo_rdy) begin
          s_d.bus_req = 1'b1;
          s_d.busy    = 1'b1;
          s_d.st      = dmatc_pkg::DMATC_GRANT;
        end
      end
      dmatc_pkg::DMATC_GRANT: begin
        // Hold here until the CPU lets go of the bus
        if (bus_gnt) begin
          s_d.st       = dmatc_pkg::DMATC_READ;
          s_d.addr     = src_addr;
          s_d.rd       = 1'b1;
          s_d.second   = 1'b0;
          s_d.clk_left = cyc_len(src_area, src_wait);
        end
      end
      dmatc_pkg::DMATC_READ: begin
        // Count down the read cycle; data is taken on its last clock
        if (s_q.clk_left == 3'h1) begin
          // Low byte first, upper byte on the second cycle
          if (s_q.second) begin
            s_d.data[15:8] = rdata[7:0];
          end else if (src_split) begin
            s_d.data[7:0] = src_addr[0] ? rdata[15:8] : rdata[7:0];
          end else begin
            s_d.data = unit16 ? rdata : {8'h00, rdata[7:0]};
          end
          if (src_split && !s_q.second) begin
            s_d.second   = 1'b1;
            s_d.addr     = src_addr + 24'h00_0001;
            s_d.clk_left = cyc_len(src_area, src_wait);
          end else begin
            s_d.st       = dmatc_pkg::DMATC_WRITE;
            s_d.second   = 1'b0;
            s_d.rd       = 1'b0;
            s_d.wr       = 1'b1;
            s_d.addr     = dst_addr;
            s_d.clk_left = cyc_len(dst_area, dst_wait);
          end
        end else begin
          s_d.clk_left = s_q.clk_left - 3'h1;
        end
        // Preload the first write word; byte writes carry the low byte
        if (s_d.st == dmatc_pkg::DMATC_WRITE) begin
          s_d.wdata = dst_split ? {8'h00, s_d.data[7:0]} : s_d.data;
        end
      end
      dmatc_pkg::DMATC_WRITE: begin
        // Same length and split rules as the read side
        if (s_q.clk_left == 3'h1) begin
          if (dst_split && !s_q.second) begin
            s_d.second   = 1'b1;
            s_d.addr     = dst_addr + 24'h00_0001;
            s_d.wdata    = {8'h00, s_q.data[15:8]};
            s_d.clk_left = cyc_len(dst_area, dst_wait);
          end else begin
            s_d.st      = dmatc_pkg::DMATC_DONE;
            s_d.wr      = 1'b0;
            s_d.bus_req = 1'b0;
            s_d.push    = 1'b1;
          end
        end else begin
          s_d.clk_left = s_q.clk_left - 3'h1;
        end
      end
      dmatc_pkg::DMATC_DONE: begin
        // Bus back to CPU for at least one clock between units
        s_d.busy = 1'b0;
        s_d.done = 1'b1;
        s_d.st   = dmatc_pkg::DMATC_IDLE;
      end
      default: begin
        // Illegal code: recover to idle
        s_d.st = dmatc_pkg::DMATC_IDLE;
      end
    endcase
  end

  // ========================================================================
  // State register
  // ========================================================================
  // Asynchronous clear puts every output low at once, except unit_data, which is read from unreset FIFO storage
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ========================================================================
  // Outputs
  // ========================================================================
  // Strobes come straight from the state word, so they never glitch
  // Output drive straight from flops
  assign bus_req   = s_q.bus_req;
  assign busy      = s_q.busy;
  assign done      = s_q.done;
  assign addr      = s_q.addr;
  assign rd_strobe = s_q.rd;
  assign wr_strobe = s_q.wr;
  assign wdata     = s_q.wdata;

  // ========================================================================
  // Unit stream buffer
  // ========================================================================
  // Push comes after the write ends; room was checked before the start
  dmatc_fifo #(
    .WIDTH (16),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .in_valid  (s_q.push),
    .in_ready  (fifo_rdy),
    .in_data   (s_q.data),
    .out_valid (unit_valid),
    .out_ready (unit_ready),
    .out_data  (unit_data)
  );

endmodule : dmatc_seq

// ===== testbench/dmatc_seq_monitor.sv
`timescale 1ns/1ps
// ==========
// Bus cycle checker
module dmatc_seq_monitor (
  // Watched ports
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic        unit16,
  input wire logic [23:0] src_addr,
  input wire logic [23:0] dst_addr,
  input wire logic [1:0]  src_area,
  input wire logic [1:0]  dst_area,
  input wire logic        src_wait,
  input wire logic        dst_wait,
  input wire logic        src_bus8,
  input wire logic        dst_bus8,
  input wire logic        bus_req,
  input wire logic        done,
  input wire logic [23:0] addr,
  input wire logic        rd_strobe,
  input wire logic        wr_strobe
);
  localparam logic [1:0] AI = dmatc_pkg::DMATC_AREA_INT; // Short alias
  localparam logic [1:0] AE = dmatc_pkg::DMATC_AREA_EXT; // Short alias
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Split transfers: low address, then address plus one
  sequence s_split_rd;
    (addr == src_addr) ##[1:3] (rd_strobe && addr == src_addr + 24'h00_0001);
  endsequence
  sequence s_split_wr;
    (addr == dst_addr) ##[1:3] (wr_strobe && addr == dst_addr + 24'h00_0001);
  endsequence
  property p_excl; !(rd_strobe && wr_strobe); endproperty
  property p_done; done |-> !bus_req && !rd_strobe && !wr_strobe ##1 !done; endproperty
  property p_wait_rd; $rose(rd_strobe) && src_area == AI && src_wait |-> rd_strobe[*2];
  endproperty
  property p_ext_rd; $rose(rd_strobe) && src_area == AE && src_wait && !unit16
    |-> rd_strobe[*3] ##1 !rd_strobe; endproperty
  property p_ext_wr; $rose(wr_strobe) && dst_area == AE && !dst_wait && !unit16
    |-> wr_strobe[*2] ##1 !wr_strobe; endproperty
  property p_odd_src; $rose(rd_strobe) && unit16 && src_addr[0] && addr == src_addr
    |-> s_split_rd; endproperty
  property p_bus8_wr; $rose(wr_strobe) && unit16 && dst_bus8 && addr == dst_addr
    |-> s_split_wr; endproperty
  property p_one_wr; $rose(wr_strobe) && unit16 && !dst_bus8 && !dst_addr[0]
    && dst_area == AI && !dst_wait |=> !wr_strobe; endproperty
  a_excl: assert property (p_excl) else $error("both strobes high");
  a_done: assert property (p_done) else $error("bus kept at done");
  a_wait_rd: assert property (p_wait_rd) else $error("wait not added");
  a_ext_rd: assert property (p_ext_rd) else $error("read length wrong");
  a_ext_wr: assert property (p_ext_wr) else $error("write length wrong");
  a_odd_src: assert property (p_odd_src) else $error("odd read not split");
  a_bus8_wr: assert property (p_bus8_wr) else $error("byte write not split");
  a_one_wr: assert property (p_one_wr) else $error("word write split");
endmodule : dmatc_seq_monitor

bind dmatc_seq dmatc_seq_monitor mon_u (.mclk(mclk), .rst_b(rst_b), .unit16(unit16),
  .src_addr(src_addr), .dst_addr(dst_addr), .src_area(src_area), .dst_area(dst_area),
  .src_wait(src_wait), .dst_wait(dst_wait), .src_bus8(src_bus8), .dst_bus8(dst_bus8),
  .bus_req(bus_req), .done(done), .addr(addr), .rd_strobe(rd_strobe), .wr_strobe(wr_strobe));

// ===== testbench/dmatc_mem_model.sv
`timescale 1ns/1ps
// ==========
// Memory behind the target bus
module dmatc_mem_model (
  input  wire logic        mclk,
  input  wire logic [23:0] addr,
  input  wire logic        rd_strobe,
  output logic      [15:0] rdata
);
  logic [15:0] last_q; // Last value shown
  // Released bus shows the inverse, so no stale value can match
  always_comb rdata = rd_strobe ? {addr[7:0] ^ 8'h3c, addr[7:0]} : ~last_q;
  always_ff @(posedge mclk) last_q <= rdata;
endmodule : dmatc_mem_model

// ===== testbench/tb_dma_transfer_cycle_timing.sv
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin bad_count++; \
  $display("mismatch t=%0t got %h exp %h", $time, a, b); end end
module tb_dma_transfer_cycle_timing;
  localparam logic [1:0] AI = dmatc_pkg::DMATC_AREA_INT; // Area aliases
  localparam logic [1:0] AS = dmatc_pkg::DMATC_AREA_SFR;
  localparam logic [1:0] AE = dmatc_pkg::DMATC_AREA_EXT;
  logic mclk, rst_b, req, unit16, src_wait, dst_wait, src_bus8, dst_bus8, bus_gnt, unit_ready;
  logic [23:0] src_addr, dst_addr;
  logic [1:0]  src_area, dst_area;
  logic bus_req, busy, done, rd_strobe, wr_strobe, unit_valid;
  logic [23:0] addr;
  logic [15:0] wdata, rdata, unit_data;
  int bad_count, comparisons;
  dmatc_seq #(.FIFO_DEPTH(16)) dut_u (.mclk(mclk), .rst_b(rst_b), .req(req), .unit16(unit16),
    .src_addr(src_addr), .dst_addr(dst_addr), .src_area(src_area), .dst_area(dst_area),
    .src_wait(src_wait), .dst_wait(dst_wait), .src_bus8(src_bus8), .dst_bus8(dst_bus8),
    .bus_req(bus_req), .bus_gnt(bus_gnt), .busy(busy), .done(done), .addr(addr),
    .rd_strobe(rd_strobe), .wr_strobe(wr_strobe), .wdata(wdata), .rdata(rdata),
    .unit_valid(unit_valid), .unit_ready(unit_ready), .unit_data(unit_data));
  dmatc_mem_model mem_u (.mclk(mclk), .addr(addr), .rd_strobe(rd_strobe), .rdata(rdata));
  // Clocks per bus cycle, and bus cycles per unit
  function automatic int len(input logic [1:0] a, input logic w);
    return (a == AE ? 2 : 1) + ((w || a == AS) ? 1 : 0);
  endfunction : len
  function automatic int ncyc(input logic u, input logic b8, input logic odd);
    return (u && (b8 || odd)) ? 2 : 1;
  endfunction : ncyc
  // Unit the model returns: low byte first, an odd split takes the upper lane
  function automatic logic [15:0] unit_exp(input logic u, input logic b8,
      input logic [23:0] sa);
    logic [7:0] a0;
    a0 = sa[7:0];
    if (!u) return {8'h00, a0};
    if (!(b8 || sa[0])) return {a0 ^ 8'h3c, a0};
    return {a0 + 8'h01, sa[0] ? (a0 ^ 8'h3c) : a0};
  endfunction : unit_exp
  // One unit; the bench plays the CPU and grants at once
  task automatic run_unit(input logic u, input logic [23:0] sa, input logic [23:0] da,
      input logic [1:0] ar, input logic [1:0] aw, input logic ws, input logic wd,
      input logic b8s, input logic b8d);
    int nr, nw, nb, er, ew;
    logic [15:0] ux, w0, wl;
    logic [23:0] ra, wa;
    nr = 0;
    nw = 0;
    nb = 0;
    er = ncyc(u, b8s, sa[0]) * len(ar, ws);
    ew = ncyc(u, b8d, da[0]) * len(aw, wd);
    ux = unit_exp(u, b8s, sa);
    {w0, wl, ra, wa} = '0;
    unit16 = u; src_addr = sa; dst_addr = da; src_area = ar; dst_area = aw;
    src_wait = ws; dst_wait = wd; src_bus8 = b8s; dst_bus8 = b8d; req = 1'b1;
    for (int k = 0; k < 60 && done !== 1'b1; k++) begin
      @(posedge mclk); #1;
      bus_gnt = bus_req;
      if (rd_strobe === 1'b1 && nr == 0) ra = addr;
      if (wr_strobe === 1'b1 && nw == 0) w0 = wdata;
      if (wr_strobe === 1'b1 && nw == 0) wa = addr;
      if (wr_strobe === 1'b1) wl = wdata;
      nr += int'(rd_strobe === 1'b1);
      nw += int'(wr_strobe === 1'b1);
      nb += int'(busy === 1'b1);
    end
    req = 1'b0;
    `CHK(done, 1'b1)
    `CHK(busy, 1'b0)
    `CHK(nr, er)
    `CHK(nw, ew)
    `CHK(nb, 2 + er + ew)
    `CHK(ra, sa)
    `CHK(wa, da)
    `CHK(w0, (u && (b8d || da[0])) ? {8'h00, ux[7:0]} : ux)
    `CHK(wl, (u && (b8d || da[0])) ? {8'h00, ux[15:8]} : ux)
    // Let the done pulse pass so the next unit starts from a quiet idle
    @(posedge mclk); #1;
    `CHK(done, 1'b0)
  endtask : run_unit
  // Waits and areas on byte units
  task automatic t_waits;
    run_unit(0, 24'h00_0010, 24'h00_0020, AI, AI, 0, 0, 0, 0);
    run_unit(0, 24'h00_0010, 24'h00_0020, AS, AS, 0, 0, 0, 0);
    run_unit(0, 24'h00_0011, 24'h00_0021, AI, AI, 1, 1, 0, 0);
    run_unit(0, 24'h00_0010, 24'h00_0020, AE, AE, 1, 0, 0, 0);
  endtask : t_waits
  // Word units over narrow buses and odd addresses
  task automatic t_widths;
    run_unit(1, 24'h00_0010, 24'h00_0020, AI, AI, 0, 0, 1, 1);
    run_unit(1, 24'h00_0011, 24'h00_0020, AI, AI, 0, 0, 0, 0);
    run_unit(1, 24'h00_0010, 24'h00_0020, AI, AI, 0, 0, 1, 0);
    run_unit(1, 24'h00_0010, 24'h00_0020, AI, AE, 0, 0, 0, 1);
    run_unit(1, 24'h00_0011, 24'h00_0020, AE, AE, 1, 1, 0, 0);
  endtask : t_widths
  // Fill the unit stream, see a request refused, then drain it
  task automatic t_fifo;
    unit_ready = 1'b0;
    for (int i = 0; i < 16; i++) run_unit(1, 24'h00_1000 + 24'(2 * i), 24'h00_0040, AI, AI,
      0, 0, 0, 0);
    req = 1'b1;
    repeat (8) begin @(posedge mclk); #1; end
    `CHK(bus_req, 1'b0)
    req = 1'b0;
    unit_ready = 1'b1;
    for (int i = 0; i < 16; i++) begin
      `CHK(unit_valid, 1'b1)
      `CHK(unit_data, {8'(8'h00 + 2 * i) ^ 8'h3c, 8'(8'h00 + 2 * i)})
      @(posedge mclk); #1;
    end
    `CHK(unit_valid, 1'b0)
  endtask : t_fifo
  task automatic finish_test;
    if (bad_count == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test
  initial begin mclk = 0; forever #12.5 mclk = ~mclk; end
  // Watchdog, far beyond the few hundred cycles needed
  initial begin #100000; bad_count++; finish_test(); end
  initial begin
    {rst_b, req, unit16, src_wait, dst_wait, src_bus8, dst_bus8, bus_gnt} = '0;
    {src_addr, dst_addr, src_area, dst_area} = '0;
    unit_ready = 1'b1;
    repeat (10) @(posedge mclk);
    `CHK(bus_req, 1'b0)
    `CHK({rd_strobe, wr_strobe}, 2'b00)
    #1 rst_b = 1'b1;
    t_waits();
    t_widths();
    t_fifo();
    finish_test();
  end
endmodule : tb_dma_transfer_cycle_timing
